// ### pkg/cfg_link_if.sv
// Serial configuration link between fabric controller and clock conditioner
`timescale 1ns/1ps
interface cfg_link_if;
  logic serialClock;
  logic serialIn;
  logic shiftEnable;
  logic applyStrobe;
  logic modeSelect;
  logic serialOut;

  modport fabric
  (
    output serialClock,
    output serialIn,
    output shiftEnable,
    output applyStrobe,
    output modeSelect,
    input  serialOut
  );

  modport conditioner
  (
    input  serialClock,
    input  serialIn,
    input  shiftEnable,
    input  applyStrobe,
    input  modeSelect,
    output serialOut
  );
endinterface

// ### pkg/clock_conditioner_cfg_pkg.sv
// Shared constants and types for the clock conditioner serial configuration path
// What this block does
// - Fabric drives all serial configuration port signals except serialOut, which the conditioner drives
// - Shift word first, then separate apply
// - Mode high selects dynamic bits, else static
// - Base configuration word is 81 bits
// - Extended variant adds bits 88 down 81
// - Fabric loads input-select bits from placement
// - Select bits 71-73, 78-80 are don't-care
package clock_conditioner_cfg_pkg;

  localparam int CFG_BASE_BITS = 81;
  localparam int CFG_EXT_BITS  = 8;
  localparam int CFG_MAX_BITS  = CFG_BASE_BITS + CFG_EXT_BITS;

  localparam int SEL_WIDTH    = 3;
  localparam int STAT_SEL_LSB = 71;
  localparam int DYN_SEL_LSB  = 77;
  localparam int DC_STAT_LSB  = 71;
  localparam int DC_UPPER_LSB = 78;

  localparam logic [CFG_MAX_BITS-1:0] SEL_ONES = {{(CFG_MAX_BITS-SEL_WIDTH){1'b0}}, 3'h7};
  localparam logic [CFG_MAX_BITS-1:0] DONT_CARE_MASK =
    (SEL_ONES << DC_STAT_LSB) | (SEL_ONES << DC_UPPER_LSB);

  localparam int CLOCK_PERIOD_NS  = 20;
  localparam int SCLK_HALF_NS     = 160;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  localparam int LINK_INS = 5;
  localparam int LNK_SCLK = 0;
  localparam int LNK_DIN  = 1;
  localparam int LNK_EN   = 2;
  localparam int LNK_UPD  = 3;
  localparam int LNK_MODE = 4;

  localparam int ADDR_W    = 8;
  localparam int TX_WORDS  = 3;
  localparam int PACK_BITS = 32 * TX_WORDS;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TX0    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RX0    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SELECT = 8'h20;

  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_MODE_BIT    = 1;
  localparam int CTRL_APPLY_BIT   = 2;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_MATCH_BIT   = 2;
  localparam int SEL_OVERRIDE_BIT = 8;

  localparam logic [31:0] CTRL_RESET   = 32'h00000004;
  localparam logic [31:0] SELECT_RESET = 32'h00000000;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_SHIFT_LO = 6'h02,
    ST_SHIFT_HI = 6'h04,
    ST_GAP      = 6'h08,
    ST_APPLY_HI = 6'h10,
    ST_APPLY_LO = 6'h20
  } ctrl_state_t;

endpackage

// ### verif/clock_conditioner_cfg_properties.sv
// Link-side assertions for the serial configuration interface
`timescale 1ns/1ps
module clock_conditioner_cfg_properties
  import clock_conditioner_cfg_pkg::*;
#(
  parameter int WORD_BITS = CFG_BASE_BITS
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic shiftEnable,
  input wire logic applyStrobe,
  input wire logic modeSelect,
  input wire logic serialOut
);
  logic [7:0] bitCount;
  logic [7:0] next_bitCount;
  logic       lastClock;

  // Counts link rising edges inside one shift frame
  always_comb
  begin
    next_bitCount = bitCount;
    if (!shiftEnable)
      next_bitCount = 8'h00;
    else if (serialClock && !lastClock)
      next_bitCount = bitCount + 8'h01;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bitCount  <= 8'h00;
      lastClock <= 1'b0;
    end
    else
    begin
      bitCount  <= next_bitCount;
      lastClock <= serialClock;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_apply_not_shift: assert property (applyStrobe |-> !shiftEnable)
    else $error("apply strobe high during shift");
  chk_gap_before_apply: assert property ($fell(shiftEnable) |-> !applyStrobe [*8])
    else $error("apply strobe too soon after shift");
  chk_strobe_width: assert property ($rose(applyStrobe) |=> applyStrobe [*7] ##1 !applyStrobe)
    else $error("apply strobe width wrong");
  chk_word_length: assert property ($fell(shiftEnable) |-> bitCount == 8'(WORD_BITS))
    else $error("shifted bit count wrong");
  chk_din_moves_low: assert property ($changed(serialIn) |-> !serialClock)
    else $error("serial data moved with clock high");
  chk_enable_moves_low: assert property ($changed(shiftEnable) |-> !serialClock)
    else $error("shift enable moved with clock high");
  chk_clock_needs_enable: assert property (serialClock |-> shiftEnable)
    else $error("link clock outside shift frame");
  chk_clock_high_half: assert property ($rose(serialClock) |=> serialClock [*7] ##1 !serialClock)
    else $error("link clock high time wrong");
  chk_first_bit_setup: assert property ($rose(shiftEnable) |-> !serialClock [*8] ##1 serialClock)
    else $error("first bit setup time wrong");

  cover property ($fell(shiftEnable));
  cover property ($fell(applyStrobe));
  cover property ($rose(modeSelect));
  cover property ($changed(serialOut));
endmodule // clock_conditioner_cfg_properties

// ### verif/test_clock_conditioner_dyn_config.sv
// Self-checking bench: APB-driven fabric end against the conditioner end
`timescale 1ns/1ps
module test_clock_conditioner_dyn_config;
  import clock_conditioner_cfg_pkg::*;
  localparam logic [PACK_BITS-1:0] WORD_A = 96'h00001ab4c0de5a5af00f1234;
  localparam logic [PACK_BITS-1:0] WORD_B = 96'h0001ffff00008001a5a57ffe;

  logic                     clock;
  logic                     resetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [ADDR_W-1:0]        paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [CFG_BASE_BITS-1:0] staticConfig;
  logic [CFG_BASE_BITS-1:0] activeConfig;
  logic                     dynamicSelected;
  logic [CFG_BASE_BITS-1:0] capWord;
  logic                     lastClk = 1'b0;
  logic [31:0]              rdData;
  logic                     rdErr;
  logic [PACK_BITS-1:0]     rxWord;
  logic [PACK_BITS-1:0]     expW;
  int                       errors = 0;
  int                       checkCount = 0;
  int                       cycles = 0;

  cfg_link_if link();
  cfg_link_ctrl cfg_link_ctrl_inst (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link);
  clock_conditioner_cfg clock_conditioner_cfg_inst (.clock, .resetn, .link, .staticConfig,
    .activeConfig, .dynamicSelected);
  clock_conditioner_cfg_properties clock_conditioner_cfg_properties_inst (.clock, .resetn,
    .serialClock(link.serialClock), .serialIn(link.serialIn), .shiftEnable(link.shiftEnable),
    .applyStrobe(link.applyStrobe), .modeSelect(link.modeSelect), .serialOut(link.serialOut));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Word as seen on the wire; first bit ends at the bottom
  always @(posedge clock)
  begin
    lastClk <= link.serialClock;
    if (link.serialClock && !lastClk && link.shiftEnable)
      capWord <= {link.serialIn, capWord[CFG_BASE_BITS-1:1]};
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic checkVal(input logic [PACK_BITS-1:0] got, input logic [PACK_BITS-1:0] exp,
                          input string what);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Idle edge first, so back-to-back calls never drive psel twice in one step
  task automatic apbXfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] data);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clock);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the cycle ceiling ends a hang
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sendWord(input logic [PACK_BITS-1:0] w, input logic [31:0] ctrl);
    int n;
    for (int i = 0; i < TX_WORDS; i++)
      apbXfer(1'b1, OFF_TX0 + ADDR_W'(4 * i), w[32 * i +: 32]);
    apbXfer(1'b1, OFF_CTRL, ctrl);
    apbXfer(1'b0, OFF_STATUS, 32'h0);
    checkVal(PACK_BITS'(rdData[STAT_DONE_BIT:STAT_BUSY_BIT]), 96'h1, "busy, done clear");
    n = 0;
    while (rdData[STAT_DONE_BIT] !== 1'b1 && n < 800)
    begin
      apbXfer(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    checkVal(PACK_BITS'(rdData[STAT_DONE_BIT]), 96'h1, "done");
    apbXfer(1'b1, OFF_STATUS, 32'h2);
    repeat (20) @(posedge clock);
    for (int i = 0; i < TX_WORDS; i++)
    begin
      apbXfer(1'b0, OFF_RX0 + ADDR_W'(4 * i), 32'h0);
      rxWord[32 * i +: 32] = rdData;
    end
  endtask

  task automatic testReset();
    apbXfer(1'b0, OFF_CTRL, 32'h0);
    checkVal(PACK_BITS'(rdData), PACK_BITS'(CTRL_RESET), "ctrl reset");
    apbXfer(1'b0, OFF_SELECT, 32'h0);
    checkVal(PACK_BITS'(rdData), PACK_BITS'(SELECT_RESET), "select reset");
    apbXfer(1'b0, 8'h40, 32'h0);
    checkVal(PACK_BITS'({rdErr, rdData}), {63'h0, 1'b1, 32'h0}, "unmapped");
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(staticConfig), "static at start");
    checkVal(PACK_BITS'({link.serialClock, link.shiftEnable, link.applyStrobe}), 96'h0, "idle");
    $display("test reset done");
  endtask

  task automatic testShift();
    sendWord(WORD_A, 32'h7);
    checkVal(PACK_BITS'(capWord), PACK_BITS'(WORD_A[80:0]), "wire order A");
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(WORD_A[80:0]), "applied A");
    checkVal(PACK_BITS'(dynamicSelected), 96'h1, "dynamic mode");
    checkVal(rxWord, 96'h0, "first readback");
    sendWord(WORD_B, 32'h3);
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(WORD_A[80:0]), "held without apply");
    checkVal(rxWord, PACK_BITS'(WORD_A[80:0]), "readback A");
    apbXfer(1'b0, OFF_STATUS, 32'h0);
    checkVal(PACK_BITS'(rdData[STAT_MATCH_BIT]), 96'h1, "match");
    sendWord(WORD_B, 32'h7);
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(WORD_B[80:0]), "applied B");
    checkVal(rxWord, PACK_BITS'(WORD_B[80:0]), "readback B");
    $display("test shift done");
  endtask

  task automatic testMode();
    apbXfer(1'b1, OFF_CTRL, 32'h4);
    repeat (10) @(posedge clock);
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(staticConfig), "static mode");
    checkVal(PACK_BITS'(dynamicSelected), 96'h0, "static flag");
    staticConfig <= ~staticConfig;
    repeat (10) @(posedge clock);
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(staticConfig), "static follows");
    apbXfer(1'b1, OFF_CTRL, 32'h6);
    repeat (10) @(posedge clock);
    checkVal(PACK_BITS'(activeConfig), PACK_BITS'(WORD_B[80:0]), "dynamic back");
    $display("test mode done");
  endtask

  task automatic testSelect();
    expW = PACK_BITS'(WORD_A[80:0]);
    expW[73:71] = 3'b101;
    expW[79:77] = 3'b010;
    apbXfer(1'b1, OFF_SELECT, 32'h115);
    sendWord(WORD_A, 32'h7);
    checkVal(PACK_BITS'(activeConfig), expW, "select override");
    // Upper transmit word keeps bits beyond the base word as written
    apbXfer(1'b0, OFF_TX0 + 8'h08, 32'h0);
    checkVal(PACK_BITS'(rdData), PACK_BITS'(WORD_A[95:64]), "tx readback");
    $display("test select done");
  endtask

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    staticConfig = 81'h123456789abcdef012345;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    testReset();
    testShift();
    testMode();
    testSelect();
    print_verdict();
  end
endmodule // test_clock_conditioner_dyn_config

// ### verilog/cfg_link_ctrl.sv
// Fabric end: APB-programmed controller that shifts and applies configuration words
`timescale 1ns/1ps
module cfg_link_ctrl
  import clock_conditioner_cfg_pkg::*;
#(
  parameter int WORD_BITS   = CFG_BASE_BITS,
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
)
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  cfg_link_if.fabric             link
);

  ctrl_state_t          state;
  ctrl_state_t          next_state;
  logic [7:0]           halfCnt;
  logic [7:0]           next_halfCnt;
  logic [6:0]           bitIdx;
  logic [6:0]           next_bitIdx;
  logic                 sclk;
  logic                 next_sclk;
  logic                 sdi;
  logic                 next_sdi;
  logic                 shiftEn;
  logic                 next_shiftEn;
  logic                 applyS;
  logic                 next_applyS;
  logic [WORD_BITS-1:0] rx;
  logic [WORD_BITS-1:0] next_rx;
  logic [WORD_BITS-1:0] txLatch;
  logic [WORD_BITS-1:0] next_txLatch;
  logic [WORD_BITS-1:0] lastTx;
  logic [WORD_BITS-1:0] next_lastTx;
  logic [WORD_BITS-1:0] txAssembled;
  logic [PACK_BITS-1:0] txFlat;
  logic [PACK_BITS-1:0] rxFlat;
  logic                 halfDone;
  logic                 doneEvent;
  logic                 matchOk;

  logic                 ack;
  logic                 next_ack;
  logic [31:0]          next_prdata;
  logic [31:0]          ctrl;
  logic [31:0]          next_ctrl;
  logic [31:0]          selectReg;
  logic [31:0]          next_selectReg;
  logic [31:0]          txWords      [TX_WORDS];
  logic [31:0]          next_txWords [TX_WORDS];
  logic                 done;
  logic                 next_done;
  logic                 apbWrite;
  logic                 startReq;
  logic                 mapped;
  logic [31:0]          rdValue;

  logic                 outSync1;
  logic                 outSync2;
  logic                 outSync3;
  logic                 outStable;
  logic                 next_outStable;

  always_comb
  begin
    for (int i = 0; i < TX_WORDS; i++)
    begin
      txFlat[32*i +: 32] = txWords[i];
    end
    txAssembled = txFlat[WORD_BITS-1:0];
    // Placement-dependent input selects may be forced after software loads the word
    if (selectReg[SEL_OVERRIDE_BIT])
    begin
      txAssembled[STAT_SEL_LSB +: SEL_WIDTH] = selectReg[2:0];
      txAssembled[DYN_SEL_LSB +: SEL_WIDTH]  = selectReg[5:3];
    end
    rxFlat  = PACK_BITS'(rx);
    // Readback ignores bits that models leave undefined
    matchOk = ((rx ^ lastTx) & ~DONT_CARE_MASK[WORD_BITS-1:0]) == '0;
  end

  always_comb
  begin
    halfDone       = (halfCnt == 8'(HALF_CYCLES - 1));
    next_outStable = (outSync2 == outSync3) ? outSync2 : outStable;
    next_state     = state;
    next_halfCnt   = halfCnt + 8'h01;
    next_bitIdx    = bitIdx;
    next_sclk      = sclk;
    next_sdi       = sdi;
    next_shiftEn   = shiftEn;
    next_applyS    = applyS;
    next_rx        = rx;
    next_txLatch   = txLatch;
    next_lastTx    = lastTx;
    doneEvent      = 1'b0;
    if (halfDone)
    begin
      next_halfCnt = 8'h00;
    end
    case (state)
      ST_IDLE:
      begin
        next_halfCnt = 8'h00;
        if (startReq)
        begin
          next_lastTx  = txLatch;
          next_txLatch = txAssembled;
          next_bitIdx  = 7'h00;
          next_shiftEn = 1'b1;
          next_sclk    = 1'b0;
          next_sdi     = txAssembled[0];
          next_state   = ST_SHIFT_LO;
        end
      end
      ST_SHIFT_LO:
      begin
        if (halfDone)
        begin
          // Sampled just before the rising edge, long after the previous shift settled
          next_rx    = {outStable, rx[WORD_BITS-1:1]};
          next_sclk  = 1'b1;
          next_state = ST_SHIFT_HI;
        end
      end
      ST_SHIFT_HI:
      begin
        if (halfDone)
        begin
          next_sclk = 1'b0;
          if (bitIdx == 7'(WORD_BITS - 1))
          begin
            next_shiftEn = 1'b0;
            next_sdi     = 1'b0;
            next_state   = ST_GAP;
          end
          else
          begin
            next_bitIdx = bitIdx + 7'h01;
            next_sdi    = txLatch[next_bitIdx];
            next_state  = ST_SHIFT_LO;
          end
        end
      end
      ST_GAP:
      begin
        if (halfDone)
        begin
          if (ctrl[CTRL_APPLY_BIT])
          begin
            next_applyS = 1'b1;
            next_state  = ST_APPLY_HI;
          end
          else
          begin
            doneEvent  = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_APPLY_HI:
      begin
        if (halfDone)
        begin
          next_applyS = 1'b0;
          next_state  = ST_APPLY_LO;
        end
      end
      ST_APPLY_LO:
      begin
        if (halfDone)
        begin
          doneEvent  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= ST_IDLE;
      halfCnt   <= 8'h00;
      bitIdx    <= 7'h00;
      sclk      <= 1'b0;
      sdi       <= 1'b0;
      shiftEn   <= 1'b0;
      applyS    <= 1'b0;
      rx        <= '0;
      txLatch   <= '0;
      lastTx    <= '0;
      outSync1  <= 1'b0;
      outSync2  <= 1'b0;
      outSync3  <= 1'b0;
      outStable <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      halfCnt   <= next_halfCnt;
      bitIdx    <= next_bitIdx;
      sclk      <= next_sclk;
      sdi       <= next_sdi;
      shiftEn   <= next_shiftEn;
      applyS    <= next_applyS;
      rx        <= next_rx;
      txLatch   <= next_txLatch;
      lastTx    <= next_lastTx;
      outSync1  <= link.serialOut;
      outSync2  <= outSync1;
      outSync3  <= outSync2;
      outStable <= next_outStable;
    end
  end

  assign link.serialClock = sclk;
  assign link.serialIn    = sdi;
  assign link.shiftEnable = shiftEn;
  assign link.applyStrobe = applyS;
  assign link.modeSelect  = ctrl[CTRL_MODE_BIT];

  always_comb
  begin
    mapped  = 1'b1;
    rdValue = 32'h00000000;
    if (paddr == OFF_CTRL)
    begin
      rdValue = {29'h0, ctrl[CTRL_APPLY_BIT], ctrl[CTRL_MODE_BIT], 1'b0};
    end
    else if (paddr == OFF_STATUS)
    begin
      rdValue = {29'h0, matchOk, done, state != ST_IDLE};
    end
    else if (paddr >= OFF_TX0 && paddr < OFF_RX0 && paddr[1:0] == 2'h0)
    begin
      rdValue = txFlat[32*((paddr - OFF_TX0) >> 2) +: 32];
    end
    else if (paddr >= OFF_RX0 && paddr < OFF_SELECT && paddr[1:0] == 2'h0)
    begin
      rdValue = rxFlat[32*((paddr - OFF_RX0) >> 2) +: 32];
    end
    else if (paddr == OFF_SELECT)
    begin
      rdValue = {23'h0, selectReg[SEL_OVERRIDE_BIT], 2'h0, selectReg[5:0]};
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  assign apbWrite = psel && penable && ack && pwrite && mapped;
  assign startReq = apbWrite && paddr == OFF_CTRL && pwdata[CTRL_START_BIT];
  assign pready   = ack;
  assign pslverr  = ack && !mapped;

  always_comb
  begin
    next_ack       = psel && penable && !ack;
    next_prdata    = prdata;
    next_ctrl      = ctrl;
    next_selectReg = selectReg;
    next_done      = done;
    for (int i = 0; i < TX_WORDS; i++)
    begin
      next_txWords[i] = txWords[i];
      if (apbWrite && paddr == OFF_TX0 + 8'(4 * i))
      begin
        next_txWords[i] = pwdata;
      end
    end
    if (psel && penable && !ack && !pwrite)
    begin
      next_prdata = rdValue;
    end
    if (apbWrite && paddr == OFF_CTRL)
    begin
      next_ctrl = pwdata & 32'h00000006;
    end
    if (apbWrite && paddr == OFF_SELECT)
    begin
      next_selectReg = pwdata & 32'h0000013f;
    end
    if (apbWrite && paddr == OFF_STATUS && pwdata[STAT_DONE_BIT])
    begin
      next_done = 1'b0;
    end
    // Completion beats a simultaneous clear so no transfer goes unreported
    if (doneEvent)
    begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ack       <= 1'b0;
      prdata    <= 32'h00000000;
      ctrl      <= CTRL_RESET;
      selectReg <= SELECT_RESET;
      done      <= 1'b0;
      for (int i = 0; i < TX_WORDS; i++)
      begin
        txWords[i] <= 32'h00000000;
      end
    end
    else
    begin
      ack       <= next_ack;
      prdata    <= next_prdata;
      ctrl      <= next_ctrl;
      selectReg <= next_selectReg;
      done      <= next_done;
      for (int i = 0; i < TX_WORDS; i++)
      begin
        txWords[i] <= next_txWords[i];
      end
    end
  end

endmodule // cfg_link_ctrl

// ### verilog/clock_conditioner_cfg.sv
// Clock conditioner end: serial shift register, apply latch and mode multiplexer
`timescale 1ns/1ps
module clock_conditioner_cfg
  import clock_conditioner_cfg_pkg::*;
#(
  parameter int WORD_BITS = CFG_BASE_BITS
)
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  cfg_link_if.conditioner           link,
  input  wire logic [WORD_BITS-1:0] staticConfig,
  output logic      [WORD_BITS-1:0] activeConfig,
  output logic                      dynamicSelected
);

  logic [LINK_INS-1:0]  rawIn;
  logic [LINK_INS-1:0]  sync1;
  logic [LINK_INS-1:0]  sync2;
  logic [LINK_INS-1:0]  sync3;
  logic [LINK_INS-1:0]  filt;
  logic [LINK_INS-1:0]  next_filt;
  logic [WORD_BITS-1:0] shiftReg;
  logic [WORD_BITS-1:0] next_shiftReg;
  logic [WORD_BITS-1:0] dynReg;
  logic [WORD_BITS-1:0] next_dynReg;
  logic [WORD_BITS-1:0] next_activeConfig;
  logic                 sclkRise;
  logic                 strobeRise;

  assign rawIn = {link.modeSelect, link.applyStrobe, link.shiftEnable,
                  link.serialIn, link.serialClock};

  always_comb
  begin
    // A level only moves once the second and third stages agree
    next_filt  = (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
    sclkRise   = next_filt[LNK_SCLK] & ~filt[LNK_SCLK];
    strobeRise = next_filt[LNK_UPD] & ~filt[LNK_UPD];
    next_shiftReg = shiftReg;
    next_dynReg   = dynReg;
    if (sclkRise && next_filt[LNK_EN])
    begin
      next_shiftReg = {next_filt[LNK_DIN], shiftReg[WORD_BITS-1:1]};
    end
    // Apply during shifting is ignored so a half-shifted word never lands
    if (strobeRise && !next_filt[LNK_EN])
    begin
      next_dynReg = shiftReg;
    end
    next_activeConfig = next_filt[LNK_MODE] ? dynReg : staticConfig;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1           <= '0;
      sync2           <= '0;
      sync3           <= '0;
      filt            <= '0;
      shiftReg        <= '0;
      dynReg          <= '0;
      activeConfig    <= '0;
      dynamicSelected <= 1'b0;
    end
    else
    begin
      sync1           <= rawIn;
      sync2           <= sync1;
      sync3           <= sync2;
      filt            <= next_filt;
      shiftReg        <= next_shiftReg;
      dynReg          <= next_dynReg;
      activeConfig    <= next_activeConfig;
      dynamicSelected <= next_filt[LNK_MODE];
    end
  end

  assign link.serialOut = shiftReg[0];

endmodule // clock_conditioner_cfg
